// [hdl/cpih_pkg.sv]
// constants, register map and types for the coprocessor instruction handler
package cpih_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] CPIH_CTRL_OFS    = 8'h00;
  localparam logic [7:0] CPIH_OPWORD_OFS  = 8'h04;
  localparam logic [7:0] CPIH_EXTWORD_OFS = 8'h08;
  localparam logic [7:0] CPIH_DISP_OFS    = 8'h0C;
  localparam logic [7:0] CPIH_SCANPC_OFS  = 8'h10;
  localparam logic [7:0] CPIH_COUNTER_OFS = 8'h14;
  localparam logic [7:0] CPIH_OPERAND_OFS = 8'h18;
  localparam logic [7:0] CPIH_CCR_OFS     = 8'h1C;
  localparam logic [7:0] CPIH_STATUS_OFS  = 8'h20;
  localparam logic [7:0] CPIH_NEXTPC_OFS  = 8'h24;
  localparam logic [7:0] CPIH_SETBYTE_OFS = 8'h28;

  // control register fields
  localparam int CPIH_CTRL_START_BIT = 0;
  localparam int CPIH_CTRL_MMU_BIT   = 1;

  // status register fields
  localparam int CPIH_ST_BUSY    = 0;
  localparam int CPIH_ST_DONE    = 1;
  localparam int CPIH_ST_TAKEN   = 2;
  localparam int CPIH_ST_TRAP    = 3;
  localparam int CPIH_ST_LINEEXC = 4;
  localparam int CPIH_ST_MMURSV  = 5;
  localparam int CPIH_ST_BADEA   = 6;
  localparam int CPIH_ST_BADOP   = 7;
  localparam int CPIH_ST_CONDTRU = 8;
  localparam int CPIH_ST_CNTEXP  = 9;
  localparam int CPIH_ST_W       = 10;

  // operation word layout
  localparam logic [3:0] CPIH_LINE_PATTERN = 4'hF;
  localparam logic [2:0] CPIH_MMU_ID       = 3'b000;
  localparam logic [2:0] CPIH_TYPE_GEN     = 3'b000;
  localparam logic [2:0] CPIH_TYPE_SCC     = 3'b001;
  localparam logic [2:0] CPIH_TYPE_BCC_W   = 3'b010;
  localparam logic [2:0] CPIH_TYPE_BCC_L   = 3'b011;
  localparam logic [2:0] CPIH_MODE_AREG    = 3'b001;
  localparam logic [2:0] CPIH_MODE_EXT     = 3'b111;
  localparam logic [2:0] CPIH_REG_ABS_L    = 3'b001;
  localparam logic [2:0] CPIH_TRAP_ONE_W   = 3'b010;
  localparam logic [2:0] CPIH_TRAP_TWO_W   = 3'b011;
  localparam logic [2:0] CPIH_TRAP_NONE    = 3'b100;

  // results and byte distances
  localparam logic [7:0]  CPIH_TRAP_VECTOR = 8'h07;
  localparam logic [7:0]  CPIH_BYTE_TRUE   = 8'hFF;
  localparam logic [7:0]  CPIH_BYTE_FALSE  = 8'h00;
  localparam logic [15:0] CPIH_COUNT_END   = 16'hFFFF;
  localparam logic [31:0] CPIH_WORD_BYTES  = 32'h0000_0002;
  localparam logic [31:0] CPIH_LONG_BYTES  = 32'h0000_0004;
  localparam logic [31:0] CPIH_ZERO_BYTES  = 32'h0000_0000;

  typedef enum logic [2:0] {
    CPIH_K_GEN,
    CPIH_K_SCC,
    CPIH_K_DBCC,
    CPIH_K_TRAP,
    CPIH_K_BCC,
    CPIH_K_BAD
  } cpih_kind_t;

  typedef enum logic {
    CPIH_IDLE,
    CPIH_CALL
  } cpih_state_t;

endpackage

// [hdl/cpih_handler.sv]
// coprocessor instruction handler with classic wishbone register slave
// Operation
// RULE_01: true branch loads extension pointer plus displacement
// RULE_02: branch displacement 16 or 32 bits by size
// RULE_03: displacement is signed byte distance
// RULE_04: branch condition taken from operation word
// RULE_05: id 000 with mmu raises line exception
// RULE_06: general id 000 reserved for mmu
// RULE_07: pass condition; coprocessor answers how continue
// RULE_08: decrement counter low word when false
// RULE_09: counter minus one falls through else branches
// RULE_10: general instruction sends command word
// RULE_11: general keeps flags unless coprocessor writes
// RULE_12: operand located by ea; coprocessor judges modes
// RULE_13: set byte all ones or zeros
// RULE_14: set byte destination data alterable only
// RULE_15: true trap takes vector 7, next pc
// RULE_16: false trap does nothing, continues
// RULE_17: trap opmode selects operand length
// RULE_18: trap operand passed unread to handler
// RULE_19: other instructions leave flags unchanged
// RULE_20: group recognised by 1111, id bits 11:9
module cpih_handler
  import cpih_pkg::*;
#(
  parameter int ADR_W = 8                      // wishbone byte address width
) (
  input  wire logic             clk_i,         // 40 MHz clock
  input  wire logic             rst_i,         // synchronous reset, active high
  input  wire logic             wb_cyc_i,      // bus cycle
  input  wire logic             wb_stb_i,      // strobe
  input  wire logic             wb_we_i,       // write enable
  input  wire logic [ADR_W-1:0] wb_adr_i,      // byte address
  input  wire logic [3:0]       wb_sel_i,      // byte lanes
  input  wire logic [31:0]      wb_dat_i,      // write data
  output logic      [31:0]      wb_dat_o,      // read data
  output logic                  wb_ack_o,      // acknowledge
  output logic                  cp_req_o,      // request to coprocessor
  output logic      [2:0]       cp_id_o,       // selected coprocessor
  output logic      [15:0]      cp_word_o,     // condition or command word
  output logic                  cp_cond_o,     // 1 condition test, 0 command
  output logic      [5:0]       cp_ea_o,       // effective address field
  input  wire logic             cp_ack_i,      // coprocessor answered
  input  wire logic             cp_true_i,     // tested condition true
  input  wire logic             cp_ccr_we_i,   // coprocessor writes flags
  input  wire logic [7:0]       cp_ccr_i,      // new flags
  input  wire logic             cp_ea_bad_i,   // coprocessor refuses the mode
  output logic                  pc_load_o,     // next pc valid pulse
  output logic      [31:0]      pc_o,          // next program counter
  output logic                  trap_o,        // trap exception pulse
  output logic      [7:0]       trap_vector_o, // trap vector number
  output logic      [31:0]      trap_operand_o,// raw trap operand
  output logic                  line_exc_o,    // line exception pulse
  output logic                  byte_store_o,  // set byte store pulse
  output logic      [7:0]       byte_data_o,   // byte to store
  output logic      [5:0]       byte_ea_o,     // destination ea field
  output logic                  busy_o         // instruction in progress
);

  initial begin
    if (ADR_W < 6 || ADR_W > 32) begin
      $error("ADR_W must lie between 6 and 32");
    end
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // data alterable: no address register, no immediate or pc relative
  function automatic logic ea_alterable(input logic [5:0] ea);
    if (ea[5:3] == CPIH_MODE_AREG) begin
      return 1'b0;
    end
    if (ea[5:3] == CPIH_MODE_EXT && ea[2:0] > CPIH_REG_ABS_L) begin
      return 1'b0;
    end
    return 1'b1;
  endfunction

  // bus slave
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        acc;
  logic        wr;
  logic [7:0]  ofs;

  // registers
  logic        mmu_q;
  logic [15:0] opword_q;
  logic [15:0] extword_q;
  logic [31:0] disp_q;
  logic [31:0] scanpc_q;
  logic [31:0] counter_q;
  logic [31:0] operand_q;
  logic [7:0]  ccr_q;
  logic [CPIH_ST_W-1:0] status_q;
  logic [31:0] nextpc_q;
  logic [7:0]  setbyte_q;
  cpih_state_t state_q;
  cpih_kind_t  kind_q;

  // decode of the operation word
  cpih_kind_t  kind;
  logic [2:0]  cp_id;
  logic [5:0]  cond;
  logic        start;
  logic        is_cond;

  assign acc   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr    = acc && wb_we_i;
  assign ofs   = 8'(wb_adr_i) & 8'hFC;
  assign start = wr && ofs == CPIH_CTRL_OFS && wb_sel_i[0]
                 && wb_dat_i[CPIH_CTRL_START_BIT] && state_q == CPIH_IDLE;

  // RULE_20: line pattern and id
  assign cp_id = opword_q[11:9];

  always_comb begin
    kind = CPIH_K_BAD;
    if (opword_q[15:12] == CPIH_LINE_PATTERN) begin
      unique case (opword_q[8:6])
        CPIH_TYPE_GEN: kind = CPIH_K_GEN;
        CPIH_TYPE_SCC: begin
          if (opword_q[5:3] == CPIH_MODE_AREG) begin
            kind = CPIH_K_DBCC;
          end else if (opword_q[5:3] == CPIH_MODE_EXT
                       && (opword_q[2:0] == CPIH_TRAP_ONE_W
                           || opword_q[2:0] == CPIH_TRAP_TWO_W
                           || opword_q[2:0] == CPIH_TRAP_NONE)) begin
            kind = CPIH_K_TRAP;
          end else begin
            kind = CPIH_K_SCC;
          end
        end
        CPIH_TYPE_BCC_W,
        CPIH_TYPE_BCC_L: kind = CPIH_K_BCC;
        default:         kind = CPIH_K_BAD;
      endcase
    end
  end

  // RULE_04: branch condition lives in the operation word
  assign cond    = (kind == CPIH_K_BCC) ? opword_q[5:0] : extword_q[5:0];
  assign is_cond = (kind != CPIH_K_GEN);

  // wishbone ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (acc && !wb_we_i) begin
      unique case (ofs)
        CPIH_CTRL_OFS:    rdat_q <= {30'h0, mmu_q, 1'b0};
        CPIH_OPWORD_OFS:  rdat_q <= {16'h0, opword_q};
        CPIH_EXTWORD_OFS: rdat_q <= {16'h0, extword_q};
        CPIH_DISP_OFS:    rdat_q <= disp_q;
        CPIH_SCANPC_OFS:  rdat_q <= scanpc_q;
        CPIH_COUNTER_OFS: rdat_q <= counter_q;
        CPIH_OPERAND_OFS: rdat_q <= operand_q;
        CPIH_CCR_OFS:     rdat_q <= {24'h0, ccr_q};
        CPIH_STATUS_OFS:  rdat_q <= {22'h0, status_q};
        CPIH_NEXTPC_OFS:  rdat_q <= nextpc_q;
        CPIH_SETBYTE_OFS: rdat_q <= {24'h0, setbyte_q};
        default:          rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // software-written operands; frozen while an instruction runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mmu_q     <= 1'b0;
      opword_q  <= 16'h0000;
      extword_q <= 16'h0000;
      disp_q    <= 32'h0000_0000;
      scanpc_q  <= 32'h0000_0000;
      operand_q <= 32'h0000_0000;
    end else if (wr && state_q == CPIH_IDLE) begin
      unique case (ofs)
        CPIH_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            mmu_q <= wb_dat_i[CPIH_CTRL_MMU_BIT];
          end
        end
        CPIH_OPWORD_OFS:  opword_q  <= 16'(lane_merge({16'h0, opword_q}, wb_dat_i, wb_sel_i));
        CPIH_EXTWORD_OFS: extword_q <= 16'(lane_merge({16'h0, extword_q}, wb_dat_i, wb_sel_i));
        CPIH_DISP_OFS:    disp_q    <= lane_merge(disp_q, wb_dat_i, wb_sel_i);
        CPIH_SCANPC_OFS:  scanpc_q  <= lane_merge(scanpc_q, wb_dat_i, wb_sel_i);
        CPIH_OPERAND_OFS: operand_q <= lane_merge(operand_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // sequencing: one coprocessor exchange per instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CPIH_IDLE;
      kind_q  <= CPIH_K_BAD;
    end else begin
      unique case (state_q)
        CPIH_IDLE: begin
          if (start) begin
            kind_q <= kind;
            // RULE_05: mmu variant, id 000, no access
            // RULE_06: general id 000 kept for the mmu
            // RULE_14: bad destination refused before access
            if (kind != CPIH_K_BAD && !(mmu_q && cp_id == CPIH_MMU_ID)
                && !(kind == CPIH_K_SCC && !ea_alterable(opword_q[5:0]))) begin
              state_q <= CPIH_CALL;
            end
          end
        end
        CPIH_CALL: begin
          if (cp_ack_i) begin
            state_q <= CPIH_IDLE;
          end
        end
      endcase
    end
  end

  // RULE_07: condition field offered to the coprocessor
  // RULE_10: general command word passed whole
  // RULE_12: ea field handed over for the coprocessor to judge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cp_id_o   <= 3'b000;
      cp_word_o <= 16'h0000;
      cp_cond_o <= 1'b0;
      cp_ea_o   <= 6'h00;
    end else if (start) begin
      cp_id_o   <= cp_id;
      cp_word_o <= is_cond ? {10'h000, cond} : extword_q;
      cp_cond_o <= is_cond;
      cp_ea_o   <= opword_q[5:0];
    end
  end

  assign cp_req_o = (state_q == CPIH_CALL);
  assign busy_o   = (state_q == CPIH_CALL);

  logic        done;
  logic        taken;
  logic [31:0] target;
  logic [31:0] fall;
  logic [15:0] cnt_dec;

  assign done    = (state_q == CPIH_CALL) && cp_ack_i;
  assign cnt_dec = counter_q[15:0] - 16'h0001;

  // RULE_01: true branch goes to pointer plus displacement
  // RULE_09: decrement loop falls through at minus one
  always_comb begin
    taken  = 1'b0;
    target = scanpc_q;
    fall   = scanpc_q;
    unique case (kind_q)
      CPIH_K_BCC: begin
        // RULE_02: size bit picks 16 or 32 bit displacement
        fall   = scanpc_q + (opword_q[6] ? CPIH_LONG_BYTES : CPIH_WORD_BYTES);
        // RULE_03: signed byte distance
        target = scanpc_q + (opword_q[6] ? disp_q : sext16(disp_q[15:0]));
        taken  = cp_true_i;
      end
      CPIH_K_DBCC: begin
        fall   = scanpc_q + CPIH_WORD_BYTES;
        target = scanpc_q + sext16(disp_q[15:0]);
        taken  = !cp_true_i && cnt_dec != CPIH_COUNT_END;
      end
      CPIH_K_TRAP: begin
        // RULE_17: opmode sets operand length
        unique case (opword_q[2:0])
          CPIH_TRAP_ONE_W: fall = scanpc_q + CPIH_WORD_BYTES;
          CPIH_TRAP_TWO_W: fall = scanpc_q + CPIH_LONG_BYTES;
          default:         fall = scanpc_q + CPIH_ZERO_BYTES;
        endcase
        target = fall;
      end
      default: begin
        fall   = scanpc_q;
        target = scanpc_q;
      end
    endcase
  end

  // counter register: software load, hardware decrement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_q <= 32'h0000_0000;
    end else if (done && kind_q == CPIH_K_DBCC && !cp_true_i) begin
      // RULE_08: only the low word counts down
      counter_q <= {counter_q[31:16], cnt_dec};
    end else if (wr && state_q == CPIH_IDLE && ofs == CPIH_COUNTER_OFS) begin
      counter_q <= lane_merge(counter_q, wb_dat_i, wb_sel_i);
    end
  end

  // flags change through the coprocessor on a general command or by a software write in idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccr_q <= 8'h00;
    end else if (done && kind_q == CPIH_K_GEN && cp_ccr_we_i) begin
      // RULE_11: coprocessor flag write
      ccr_q <= cp_ccr_i;
    end else if (wr && state_q == CPIH_IDLE && ofs == CPIH_CCR_OFS && wb_sel_i[0]) begin
      ccr_q <= wb_dat_i[7:0];
    end
  end
  // RULE_19: no other path writes the flags

  // results towards the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_o      <= 1'b0;
      pc_o           <= 32'h0000_0000;
      nextpc_q       <= 32'h0000_0000;
      trap_o         <= 1'b0;
      trap_vector_o  <= 8'h00;
      trap_operand_o <= 32'h0000_0000;
      line_exc_o     <= 1'b0;
      byte_store_o   <= 1'b0;
      byte_data_o    <= 8'h00;
      byte_ea_o      <= 6'h00;
      setbyte_q      <= 8'h00;
    end else begin
      pc_load_o    <= done;
      trap_o       <= 1'b0;
      byte_store_o <= 1'b0;
      line_exc_o   <= start && kind != CPIH_K_GEN && kind != CPIH_K_BAD
                      && mmu_q && cp_id == CPIH_MMU_ID;
      if (done) begin
        pc_o     <= taken ? target : fall;
        nextpc_q <= taken ? target : fall;
      end
      // RULE_13: all ones when true, all zeros when false
      if (done && kind_q == CPIH_K_SCC) begin
        byte_store_o <= 1'b1;
        byte_data_o  <= cp_true_i ? CPIH_BYTE_TRUE : CPIH_BYTE_FALSE;
        byte_ea_o    <= opword_q[5:0];
        setbyte_q    <= cp_true_i ? CPIH_BYTE_TRUE : CPIH_BYTE_FALSE;
      end
      // RULE_15: true trap, vector 7, next address stacked
      // RULE_16: false trap only advances the pc
      if (done && kind_q == CPIH_K_TRAP && cp_true_i) begin
        trap_o        <= 1'b1;
        trap_vector_o <= CPIH_TRAP_VECTOR;
        // RULE_18: operand forwarded uninterpreted
        trap_operand_o <= (opword_q[2:0] == CPIH_TRAP_NONE) ? 32'h0000_0000 : operand_q;
      end
    end
  end

  // status: cleared by a start, set by completion; start only in idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (start) begin
      status_q <= '0;
      status_q[CPIH_ST_BUSY] <= 1'b1;
      if (kind == CPIH_K_BAD) begin
        status_q[CPIH_ST_DONE]  <= 1'b1;
        status_q[CPIH_ST_BUSY]  <= 1'b0;
        status_q[CPIH_ST_BADOP] <= 1'b1;
      end else if (mmu_q && cp_id == CPIH_MMU_ID) begin
        status_q[CPIH_ST_DONE] <= 1'b1;
        status_q[CPIH_ST_BUSY] <= 1'b0;
        if (kind == CPIH_K_GEN) begin
          status_q[CPIH_ST_MMURSV] <= 1'b1;
        end else begin
          status_q[CPIH_ST_LINEEXC] <= 1'b1;
        end
      end else if (kind == CPIH_K_SCC && !ea_alterable(opword_q[5:0])) begin
        status_q[CPIH_ST_DONE]  <= 1'b1;
        status_q[CPIH_ST_BUSY]  <= 1'b0;
        status_q[CPIH_ST_BADEA] <= 1'b1;
      end
    end else if (done) begin
      status_q[CPIH_ST_BUSY]    <= 1'b0;
      status_q[CPIH_ST_DONE]    <= 1'b1;
      status_q[CPIH_ST_TAKEN]   <= taken;
      status_q[CPIH_ST_CONDTRU] <= cp_true_i;
      status_q[CPIH_ST_TRAP]    <= kind_q == CPIH_K_TRAP && cp_true_i;
      status_q[CPIH_ST_BADEA]   <= kind_q == CPIH_K_GEN && cp_ea_bad_i;
      status_q[CPIH_ST_CNTEXP]  <= kind_q == CPIH_K_DBCC && !cp_true_i
                                   && cnt_dec == CPIH_COUNT_END;
    end
  end

endmodule

// [tb/cpih_handler_asserts.sv]
// port checker for the coprocessor instruction handler
module cpih_handler_asserts
  import cpih_pkg::*;
(
  input wire logic        clk_i,         // clock
  input wire logic        rst_i,         // reset
  input wire logic        wb_cyc_i,      // bus cycle
  input wire logic        wb_stb_i,      // strobe
  input wire logic        wb_ack_o,      // acknowledge
  input wire logic        cp_req_o,      // request
  input wire logic [2:0]  cp_id_o,       // coprocessor id
  input wire logic [15:0] cp_word_o,     // word passed
  input wire logic        cp_cond_o,     // condition word
  input wire logic        cp_ack_i,      // answer
  input wire logic        cp_true_i,     // condition result
  input wire logic        pc_load_o,     // pc pulse
  input wire logic        trap_o,        // trap pulse
  input wire logic [7:0]  trap_vector_o, // vector
  input wire logic        line_exc_o,    // line exception
  input wire logic        byte_store_o,  // store pulse
  input wire logic [7:0]  byte_data_o,   // stored byte
  input wire logic [5:0]  byte_ea_o,     // destination
  input wire logic        busy_o         // busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");
  property p_req_hold;
    cp_req_o && !cp_ack_i |=> cp_req_o && busy_o && $stable(cp_word_o) && $stable(cp_id_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_req_drop;
    cp_req_o && cp_ack_i |=> !cp_req_o && !busy_o;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after answer");
  property p_cond_word;
    cp_req_o && cp_cond_o |-> cp_word_o[15:6] == 10'h000;
  endproperty
  a_cond_word: assert property (p_cond_word) else $error("condition word malformed");
  property p_trap_vec;
    trap_o |-> trap_vector_o == CPIH_TRAP_VECTOR && $past(cp_ack_i && cp_true_i);
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap without true answer");
  property p_trap_false;
    cp_req_o && cp_ack_i && !cp_true_i |=> !trap_o;
  endproperty
  a_trap_false: assert property (p_trap_false) else $error("trap on false");
  property p_set_byte;
    byte_store_o |-> byte_data_o == ($past(cp_true_i) ? 8'hFF : 8'h00);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("stored byte wrong");
  property p_set_ea;
    byte_store_o |-> byte_ea_o[5:3] != 3'b001 && (byte_ea_o[5:3] != 3'b111 || byte_ea_o[2:1] == 2'b00);
  endproperty
  a_set_ea: assert property (p_set_ea) else $error("store to illegal mode");
  property p_pc_pulse;
    pc_load_o |=> !pc_load_o;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("pc pulse too long");
  property p_line;
    line_exc_o |-> !$past(cp_req_o) ##1 !line_exc_o && !cp_req_o;
  endproperty
  a_line: assert property (p_line) else $error("line exception with access");
endmodule

// [tb/cpih_copro_model.sv]
// behavioural coprocessor answering the handler after a set delay
module cpih_copro_model (
  input  wire logic        clk_i,        // clock
  input  wire logic        rst_i,        // reset
  input  wire logic        req_i,        // request from handler
  input  wire logic [15:0] word_i,       // word passed
  input  wire logic        cfg_true_i,   // answer to give
  input  wire logic [3:0]  cfg_delay_i,  // answer delay
  input  wire logic        cfg_ccr_we_i, // write flags
  input  wire logic [7:0]  cfg_ccr_i,    // flags to write
  input  wire logic        cfg_ea_bad_i, // refuse the mode
  output logic             ack_o,        // answer
  output logic             true_o,       // condition result
  output logic             ccr_we_o,     // flag write
  output logic      [7:0]  ccr_o,        // flags
  output logic             ea_bad_o,     // mode refused
  output logic      [15:0] seen_word_o   // last word received
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || ack_o) begin
      wait_q <= 4'h0;
      ack_o  <= 1'b0;
    end else if (wait_q == cfg_delay_i) ack_o <= 1'b1;
    else wait_q <= wait_q + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (req_i) seen_word_o <= word_i;
  end
  // outside the answer the lines show nothing useful
  assign true_o   = ack_o ? cfg_true_i : ~cfg_true_i;
  assign ccr_we_o = ack_o & cfg_ccr_we_i;
  assign ccr_o    = ack_o ? cfg_ccr_i : ~cfg_ccr_i;
  assign ea_bad_o = ack_o & cfg_ea_bad_i;
endmodule

// [tb/tb.sv]
// self-checking bench for the coprocessor instruction handler
module tb
  import cpih_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] op, ext; logic [31:0] disp, scan, cnt; logic tru;
    logic [31:0] pc, cntx; logic [15:0] word; logic trap; logic [1:0] chk;
  } cpih_row_t;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, req, cond, cp_ack, cp_true, ccr_we, ea_bad;
  logic [7:0] wb_adr, ccr, ccr_cfg, tvec, bdata;
  logic [3:0] wb_sel, dly;
  logic [31:0] wb_dat, wb_rd, pc, topnd, st, v;
  logic [15:0] word, seen;
  logic [2:0] id;
  logic [5:0] ea, bea;
  logic c_true, c_we, c_bad, pcl, trp, lex, bst, busy;
  int error_cnt, tests_run;
  cpih_row_t rows[12] = '{
    '{16'hF285, 0, 32'hFFF0, 32'h1000, 0, 1, 32'h0FF0, 0, 16'h5, 0, 0},
    '{16'hF285, 0, 32'hFFF0, 32'h1000, 0, 0, 32'h1002, 0, 16'h5, 0, 0},
    '{16'hF2C5, 0, 32'h10000, 32'h1000, 0, 1, 32'h11000, 0, 16'h5, 0, 0},
    '{16'hF24A, 3, 32'h10, 32'h2000, 5, 1, 32'h2002, 5, 16'h3, 0, 0},
    '{16'hF24A, 3, 32'hFFF0, 32'h2000, 5, 0, 32'h1FF0, 4, 16'h3, 0, 0},
    '{16'hF24A, 3, 32'h10, 32'h2000, 0, 0, 32'h2002, 32'hFFFF, 16'h3, 0, 0},
    '{16'hF27A, 7, 0, 32'h3000, 0, 0, 32'h3002, 0, 16'h7, 0, 0},
    '{16'hF27B, 7, 0, 32'h3000, 0, 1, 32'h3004, 0, 16'h7, 1, 1},
    '{16'hF27C, 7, 0, 32'h3000, 0, 1, 32'h3000, 0, 16'h7, 1, 1},
    '{16'hF242, 16'hA, 0, 32'h4000, 0, 1, 32'h4000, 0, 16'hA, 0, 2},
    '{16'hF279, 16'hA, 0, 32'h4000, 0, 0, 32'h4000, 0, 16'hA, 0, 2},
    '{16'hF210, 16'h1234, 0, 32'h5000, 0, 0, 32'h5000, 0, 16'h1234, 0, 0}};

  cpih_handler DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .cp_req_o(req), .cp_id_o(id), .cp_word_o(word),
    .cp_cond_o(cond), .cp_ea_o(ea), .cp_ack_i(cp_ack), .cp_true_i(cp_true),
    .cp_ccr_we_i(ccr_we), .cp_ccr_i(ccr), .cp_ea_bad_i(ea_bad), .pc_load_o(pcl), .pc_o(pc),
    .trap_o(trp), .trap_vector_o(tvec), .trap_operand_o(topnd), .line_exc_o(lex),
    .byte_store_o(bst), .byte_data_o(bdata), .byte_ea_o(bea), .busy_o(busy));
  cpih_copro_model u_cop (.clk_i(clk), .rst_i(rst), .req_i(req), .word_i(word),
    .cfg_true_i(c_true), .cfg_delay_i(dly), .cfg_ccr_we_i(c_we), .cfg_ccr_i(ccr_cfg),
    .cfg_ea_bad_i(c_bad), .ack_o(cp_ack), .true_o(cp_true), .ccr_we_o(ccr_we), .ccr_o(ccr),
    .ea_bad_o(ea_bad), .seen_word_o(seen));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // one classic cycle, held until the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    v = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input cpih_row_t r, input logic [31:0] ctl);
    int n;
    c_true <= r.tru;
    wb(1, CPIH_OPWORD_OFS, {16'h0, r.op});
    wb(1, CPIH_EXTWORD_OFS, {16'h0, r.ext});
    wb(1, CPIH_DISP_OFS, r.disp);
    wb(1, CPIH_SCANPC_OFS, r.scan);
    wb(1, CPIH_COUNTER_OFS, r.cnt);
    wb(1, CPIH_OPERAND_OFS, 32'hA5A5_5A5A);
    wb(1, CPIH_CTRL_OFS, ctl);
    n = 0;
    do begin
      wb(0, CPIH_STATUS_OFS, 0);
      n++;
    end while (v[CPIH_ST_DONE] !== 1'b1 && n < 50);
    // poll limit ran out: counts as a mismatch
    if (v[CPIH_ST_DONE] !== 1'b1) error_cnt++;
    st = v;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    final_report();
  end

  initial begin
    {wb_cyc, wb_stb, wb_we, c_true, c_we, c_bad} = '0;
    {wb_adr, wb_dat, ccr_cfg} = '0;
    wb_sel = 4'hF;
    dly = 4'h2;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(0, CPIH_STATUS_OFS, 0);
    chk(0, v);
    wb(1, CPIH_STATUS_OFS, 32'hFFFF_FFFF);
    wb(0, CPIH_STATUS_OFS, 0);
    chk(0, v);
    wb(0, 8'h3C, 0);
    chk(0, v);
    foreach (rows[i]) begin
      run(rows[i], 1);
      wb(0, CPIH_NEXTPC_OFS, 0);
      chk(rows[i].pc, v);
      wb(0, CPIH_COUNTER_OFS, 0);
      chk(rows[i].cntx, v);
      chk(rows[i].pc, pc);
      chk({26'h0, rows[i].op[5:0]}, {26'h0, ea});
      chk({29'h0, rows[i].op[11:9]}, {29'h0, id});
      chk({16'h0, rows[i].word}, {16'h0, seen});
      chk({31'h0, rows[i].trap}, {31'h0, st[CPIH_ST_TRAP]});
      if (rows[i].chk == 2'd1) chk(rows[i].op[2] ? 0 : 32'hA5A5_5A5A, topnd);
      if (rows[i].chk == 2'd2) chk({24'h0, {8{rows[i].tru}}}, {24'h0, bdata});
    end
    // start samples the variant bit already held, so set it first
    wb(1, CPIH_CTRL_OFS, 32'h2);
    run('{16'hF085, 0, 0, 32'h1000, 0, 1, 0, 0, 0, 0, 0}, 3);
    chk(1, {31'h0, st[CPIH_ST_LINEEXC]});
    run('{16'hF010, 0, 0, 32'h1000, 0, 1, 0, 0, 0, 0, 0}, 3);
    chk(1, {31'h0, st[CPIH_ST_MMURSV]});
    run('{16'hF27D, 0, 0, 32'h1000, 0, 1, 0, 0, 0, 0, 0}, 1);
    chk(1, {31'h0, st[CPIH_ST_BADEA]});
    run('{16'h1234, 0, 0, 32'h1000, 0, 1, 0, 0, 0, 0, 0}, 1);
    chk(1, {31'h0, st[CPIH_ST_BADOP]});
    wb(1, CPIH_CCR_OFS, 32'h15);
    c_we <= 1'b1;
    ccr_cfg <= 8'hA3;
    dly <= 4'h9;
    run(rows[11], 1);
    wb(0, CPIH_CCR_OFS, 0);
    chk(32'hA3, v);
    // flag write offered on a branch must be ignored
    ccr_cfg <= 8'h5C;
    run(rows[0], 1);
    wb(0, CPIH_NEXTPC_OFS, 0);
    chk(rows[0].pc, v);
    wb(0, CPIH_CCR_OFS, 0);
    chk(32'hA3, v);
    c_we <= 1'b0;
    run(rows[11], 1);
    wb(0, CPIH_CCR_OFS, 0);
    chk(32'hA3, v);
    c_bad <= 1'b1;
    run(rows[11], 1);
    chk(1, {31'h0, st[CPIH_ST_BADEA]});
    final_report();
  end
endmodule

bind cpih_handler cpih_handler_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cp_req_o, .cp_id_o, .cp_word_o, .cp_cond_o, .cp_ack_i, .cp_true_i, .pc_load_o, .trap_o,
  .trap_vector_o, .line_exc_o, .byte_store_o, .byte_data_o, .byte_ea_o, .busy_o);
